// [include/icout_regs.vh]
// constants for the incremental / commutation output block
// Overview of operation
// - three shared pins carry quadrature plus index or commutation, by protocol bit
// - enable bit turns the selected outputs on or off
// - codes 0 to 14 give 2^(14-code) quadrature cycles per revolution
// - in commutation mode the code plus one is the pole-pair count
// - too fast rotation may skip a quadrature state unless slew limited
// - invert bit flips all three pin levels in both modes
// - index pulse once per revolution marks the zero position
// - index pulse width is one of four settings
// - during power-on delay the quadrature output is held in the error state; commutation output is not held
// - catch-up steps the shorter way, at most half a turn of states
// - after catch-up the output tracks the angle normally
// - zero slew limit skips catch-up and follows the angle directly
// - nonzero slew limit counts up after reset or error state
// - suppress bit with error reporting skips count-up after reset
// - quadrature states 00,01,11,10 advance with increasing angle
// - nonzero slew limit sets minimum hold time of each state
// - zero lies on index rising edge going up, falling edge going down
`ifndef ICOUT_REGS_VH
`define ICOUT_REGS_VH
`define ICOUT_ANGLE_W 16
`define ICOUT_SLEW_W 6
`define ICOUT_RES_MAX 4'hE
`define ICOUT_SLEW_BASE_NS 125
`define ICOUT_CLK_NS 25
`define ICOUT_SLEW_STEP_CYC ((`ICOUT_SLEW_BASE_NS + `ICOUT_CLK_NS - 1) / `ICOUT_CLK_NS)
`define ICOUT_PO_DELAY_US 16000
`define ICOUT_PO_DELAY_CYC (`ICOUT_PO_DELAY_US * 1000 / `ICOUT_CLK_NS)
`endif

// [verilog/icout_slew_timer.v]
// minimum state hold timer for quadrature steps
`timescale 1ns/100ps
`include "icout_regs.vh"
module icout_slew_timer
(
	input wire i_clk,
	input wire i_rst_n,
	input wire [5:0] i_slew,
	input wire i_step,
	output wire o_ready
);
	localparam STEP = `ICOUT_SLEW_STEP_CYC;
	reg [11:0] cnt_r;
	reg [11:0] cnt_nxt;
	// hold time (slew + 1) * base step, restarted by each step
	always @*
	begin
		cnt_nxt = cnt_r;
		if (i_step)
			cnt_nxt = (({6'h00, i_slew} + 12'h001) * STEP[11:0]) - 12'h001;
		else if (cnt_r != 12'h000)
			cnt_nxt = cnt_r - 12'h001;
	end
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			cnt_r <= 12'h000;
		else
			cnt_r <= cnt_nxt;
	end
	assign o_ready = (cnt_r == 12'h000);
endmodule // icout_slew_timer

// [verilog/icout_commutate.v]
// commutation sector decoder for one to sixteen pole pairs
`timescale 1ns/100ps
`include "icout_regs.vh"
module icout_commutate
(
	input wire [15:0] i_angle,
	input wire [3:0] i_code,
	output wire [2:0] o_uvw
);
	wire [20:0] elec;
	wire [2:0] sector;
	wire [18:0] prod;
	// electrical angle = mechanical angle * pole pairs, low 16 bits
	assign elec = {5'h00, i_angle} * ({17'h00000, i_code} + 21'h000001);
	// six sectors per electrical turn
	// six times a full turn needs nineteen bits
	assign prod = {3'h0, elec[15:0]} * 19'h00006;
	assign sector = prod[18:16];
	assign o_uvw = (sector == 3'h0) ? 3'b100 :
		(sector == 3'h1) ? 3'b110 :
		(sector == 3'h2) ? 3'b010 :
		(sector == 3'h3) ? 3'b011 :
		(sector == 3'h4) ? 3'b001 : 3'b101;
endmodule // icout_commutate

// [verilog/icout_top.v]
// incremental quadrature / commutation output generator
`timescale 1ns/100ps
`include "icout_regs.vh"
module icout_top
#(
	parameter PO_DELAY_CYC = `ICOUT_PO_DELAY_CYC
)
(
	input wire i_clk,
	input wire i_rst_n,
	input wire [15:0] i_angle,
	input wire i_output_protocol_select,
	input wire i_incremental_output_enable,
	input wire [3:0] i_output_resolution_code,
	input wire i_output_polarity_invert,
	input wire [1:0] i_index_width_select,
	input wire [5:0] i_edge_slew_limit,
	input wire i_startup_countup_suppress,
	input wire i_error_report_enable,
	input wire i_error,
	output reg [2:0] o_pins,
	output wire o_slew_active,
	output wire o_catchup_busy
);
	localparam ST_DELAY = 2'd0;
	localparam ST_CATCH = 2'd1;
	localparam ST_RUN = 2'd2;
	reg [1:0] st_r;
	reg [1:0] st_nxt;
	reg [31:0] dly_r;
	reg [15:0] pos_r;
	reg [15:0] pos_nxt;
	wire [15:0] tgt;
	wire [15:0] diff;
	wire [15:0] unit;
	wire ready;
	wire step;
	wire want_up;
	wire want_dn;
	wire [2:0] commutation_output;
	reg [1:0] ab;
	reg idx;
	reg [2:0] raw;
	wire err_hold;

	// position step size per quadrature state
	function [15:0] step_unit;
		input [3:0] code;
		begin
			if (code > `ICOUT_RES_MAX)
				step_unit = 16'h0001;
			else
				step_unit = 16'h0001 << code;
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// target in quadrature-state units
	assign unit = step_unit(i_output_resolution_code);
	// aligned to the top so the sign bit marks half a turn
	assign tgt = i_angle & ~(unit - 16'h0001);
	assign diff = tgt - (pos_r & ~(unit - 16'h0001));
	assign want_up = (diff != 16'h0000) && !diff[15];
	assign want_dn = diff[15];
	assign err_hold = i_error && i_error_report_enable;
	assign step = (st_r != ST_DELAY) && ready && (want_up || want_dn);

	icout_slew_timer u_slew
	(
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_slew(i_edge_slew_limit),
		.i_step(step),
		.o_ready(ready)
	);

	icout_commutate u_comm
	(
		.i_angle(i_angle),
		.i_code(i_output_resolution_code),
		.o_uvw(commutation_output)
	);

	////////////////////////////////////////////////////////////////////
	// startup and error sequencing
	always @*
	begin
		st_nxt = st_r;
		case (st_r)
			ST_DELAY:
				if (dly_r == 32'h0 && !err_hold)
				begin
					if (i_edge_slew_limit == 6'h00)
						st_nxt = ST_RUN;
					else if (i_startup_countup_suppress && i_error_report_enable)
						st_nxt = ST_RUN;
					else
						st_nxt = ST_CATCH;
				end
			ST_CATCH:
				if (err_hold)
					st_nxt = ST_DELAY;
				else if (diff == 16'h0000)
					st_nxt = ST_RUN;
			ST_RUN:
				if (err_hold)
					st_nxt = ST_DELAY;
			default:
				st_nxt = ST_DELAY;
		endcase
	end

	// position: jump when unlimited or on a suppressed start, else one state per hold time
	always @*
	begin
		pos_nxt = pos_r;
		if (st_r == ST_DELAY)
		begin
			if (st_nxt == ST_RUN)
				pos_nxt = i_angle;
		end
		else if (i_edge_slew_limit == 6'h00 && st_r == ST_RUN)
			pos_nxt = i_angle;
		else if (step && want_up)
			pos_nxt = pos_r + unit;
		else if (step && want_dn)
			pos_nxt = pos_r - unit;
	end

	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_r <= ST_DELAY;
			dly_r <= 32'h0;
			pos_r <= 16'h0000;
		end
		else
		begin
			st_r <= st_nxt;
			pos_r <= pos_nxt;
			if (st_r != ST_DELAY && st_nxt == ST_DELAY)
				dly_r <= PO_DELAY_CYC;
			else if (dly_r != 32'h0)
				dly_r <= dly_r - 32'h1;
		end
	end

	// pins are held low at the first edge after reset
	reg armed_r;
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			armed_r <= 1'b0;
		else
			armed_r <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	// quadrature and index decode from the position
	always @*
	begin
		case (pos_r[i_output_resolution_code +: 2] & 2'b11)
			2'd0: ab = 2'b00;
			2'd1: ab = 2'b01;
			2'd2: ab = 2'b11;
			default: ab = 2'b10;
		endcase
		// index high from zero for select plus one states, rising edge at zero
		case (i_index_width_select)
			2'd0: idx = ((pos_r >> i_output_resolution_code) == 16'h0000);
			2'd1: idx = ((pos_r >> i_output_resolution_code) <= 16'h0001);
			2'd2: idx = ((pos_r >> i_output_resolution_code) <= 16'h0002);
			default: idx = ((pos_r >> i_output_resolution_code) <= 16'h0003);
		endcase
		if (i_output_protocol_select)
			raw = commutation_output;
		else
			raw = {ab, idx};
	end

	// registered pins, low when disabled or before the first edge, at the invert level when held
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_pins <= 3'h0;
		else if (!i_incremental_output_enable || !armed_r)
			o_pins <= 3'h0;
		else if (st_r == ST_DELAY && !i_output_protocol_select)
			o_pins <= {3{i_output_polarity_invert}};
		else
			o_pins <= raw ^ {3{i_output_polarity_invert}};
	end

	assign o_slew_active = step && (st_r == ST_RUN) &&
		((diff > unit) && !diff[15] ||
		(diff < (16'h0000 - unit)) && diff[15]);
	assign o_catchup_busy = (st_r == ST_CATCH);
endmodule // icout_top

// [testbench/icout_props.sv]
// port assertions for the incremental output block
`timescale 1ns/100ps
module icout_props
#(
	parameter PO_DELAY_CYC = 20
)
(
	input wire i_clk,
	input wire i_rst_n,
	input wire [15:0] i_angle,
	input wire i_output_protocol_select,
	input wire i_incremental_output_enable,
	input wire [3:0] i_output_resolution_code,
	input wire i_output_polarity_invert,
	input wire [1:0] i_index_width_select,
	input wire [5:0] i_edge_slew_limit,
	input wire i_error,
	input wire [2:0] o_pins,
	input wire o_catchup_busy
);
	// mode shorthands and quadrature state of the angle
	wire en = i_incremental_output_enable;
	wire sel = i_output_protocol_select;
	wire inv = i_output_polarity_invert;
	wire sl0 = ~|i_edge_slew_limit;
	wire [1:0] ab = o_pins[2:1];
	wire [15:0] st = i_angle >> i_output_resolution_code;
	wire qs = en & !sel & !i_error & !sl0;
	wire qd = en & !sel & !i_error & !inv & !o_catchup_busy & sl0;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_calm;
		(qd && $stable({i_angle, i_output_resolution_code,
			i_index_width_select})) [*4];
	endsequence
	property p_off; (!en & !inv) [*2] |-> o_pins == 3'h0; endproperty
	a_off: assert property (p_off) else $error("idle pins");
	property p_gray; qs [*2] |-> $countones(ab ^ $past(ab)) < 2; endproperty
	a_gray: assert property (p_gray) else $error("ab jump");
	property p_hold; qs && $changed(ab) |=> $stable(ab) [*8]; endproperty
	a_hold: assert property (p_hold) else $error("short state");
	property p_dir; s_calm |-> ab == {st[1], ^st[1:0]}; endproperty
	a_dir: assert property (p_dir) else $error("ab state");
	property p_idx; s_calm |-> o_pins[0] == (st <= i_index_width_select);
	endproperty
	a_idx: assert property (p_idx) else $error("index");
	property p_inv; $stable(i_angle) ##1 ($stable({i_angle, sel, en,
		i_index_width_select, i_output_resolution_code}) && $changed(inv) &&
		en && !o_catchup_busy)
		|=> o_pins == ~$past(o_pins); endproperty
	a_inv: assert property (p_inv) else $error("invert");
	property p_cm; (en & sel & !inv) [*4] |-> o_pins != 3'h0 && o_pins != 3'h7;
	endproperty
	a_cm: assert property (p_cm) else $error("commutation");
	property p_cu; $rose(o_catchup_busy) |-> ##[1:1000] !o_catchup_busy;
	endproperty
	a_cu: assert property (p_cu) else $error("catch-up long");
endmodule // icout_props
bind icout_top icout_props #(.PO_DELAY_CYC(PO_DELAY_CYC)) icout_props_i (.*);

// [testbench/icout_rx.sv]
// quadrature receiver model
`timescale 1ns/100ps
module icout_rx
(
	input wire i_clk,
	input wire i_rst_n,
	input wire [2:0] i_pins,
	output reg [15:0] o_count
);
	reg [1:0] ph_r;
	wire [1:0] ph = {i_pins[2], ^i_pins[2:1]};
	// b edge first counts up, a edge first counts down
	always @(posedge i_clk or negedge i_rst_n)
		if (!i_rst_n)
			{ph_r, o_count} <= 18'h00000;
		else
		begin
			ph_r <= ph;
			if (ph == ph_r + 2'h1)
				o_count <= o_count + 16'h0001;
			else if (ph == ph_r - 2'h1)
				o_count <= o_count - 16'h0001;
		end
endmodule // icout_rx

// [testbench/incremental_commutation_output_test.sv]
// bench for the incremental output block
`timescale 1ns/100ps
module incremental_commutation_output_test;
	localparam [17:0] TBL = 18'h296B4;
	reg clk = 1'b0, rst_n = 1'b0, sel = 1'b0, en = 1'b0, inv = 1'b0;
	reg [15:0] ang = 16'h0000, lf = 16'h0037, n;
	reg [3:0] code = 4'h3;
	reg [1:0] wid = 2'h0;
	reg [5:0] slew = 6'h00;
	reg [2:0] eq[$];
	wire [2:0] pins;
	wire [15:0] cnt;
	wire busy;
	integer num_errors = 0, num_checks = 0, cyc = 0, k, w;
	event chk;
	icout_top #(.PO_DELAY_CYC(20)) icout_top_i (.i_clk(clk), .i_rst_n(rst_n),
		.i_angle(ang), .i_output_protocol_select(sel),
		.i_incremental_output_enable(en), .i_output_resolution_code(code),
		.i_output_polarity_invert(inv), .i_index_width_select(wid),
		.i_edge_slew_limit(slew), .i_startup_countup_suppress(1'b0),
		.i_error_report_enable(1'b0), .i_error(1'b0), .o_pins(pins),
		.o_slew_active(), .o_catchup_busy(busy));
	icout_rx icout_rx_i (.i_clk(clk), .i_rst_n(rst_n), .i_pins(pins),
		.o_count(cnt));
	initial forever #12.5 clk = ~clk;
	function [15:0] lfsr(input [15:0] v);
		lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task check(input [15:0] s, input [15:0] e);
	begin
		num_checks = num_checks + 1;
		if (s !== e)
		begin
			num_errors = num_errors + 1;
			$display("Error %0t seen %h expected %h", $time, s, e);
		end
	end
	endtask
	task give_verdict;
	begin
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	// apply an angle, note the expected pins once settled
	task put(input [15:0] a, input [2:0] e);
	begin
		@(posedge clk) ang <= a;
		repeat (4) @(posedge clk);
		eq.push_back(e);
		@(negedge clk) -> chk;
	end
	endtask
	// compare each result with the oldest note
	always @(chk) check(pins, eq.pop_front());
	// give up on a hung run
	always @(posedge clk)
	begin
		cyc = cyc + 1;
		if (cyc > 9000)
		begin
			num_errors = num_errors + 1;
			give_verdict;
		end
	end
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		// quadrature without slew: random angle, code, width, polarity
		for (k = 0; k < 48; k = k + 1)
		begin
			lf = lfsr(lf);
			@(posedge clk);
			en <= 1'b1;
			code <= 4'h3 + lf[3:0] % 4'hC;
			wid <= lf[5:4];
			inv <= lf[6];
			@(negedge clk);
			n = lf >> code;
			put(lf, {n[1], ^n[1:0], (n <= wid)} ^ {3{inv}});
		end
		$display("quadrature test done");
		// commutation at sector centres, one, eight and sixteen pole pairs
		for (k = 0; k < 18; k = k + 1)
		begin
			@(posedge clk);
			sel <= 1'b1;
			inv <= k[0];
			code <= 4'(k / 6 * 7 + k / 12);
			@(negedge clk);
			n = (2 * (k % 6) + 1) * 65536 / (12 * (code + 1));
			put(n, TBL[3 * (k % 6) +: 3] ^ {3{inv}});
		end
		$display("commutation test done");
		// catch-up after reset, up and down the short way
		for (k = 0; k < 2; k = k + 1)
		begin
			@(posedge clk);
			{sel, inv, wid, code, slew} <= {4'h0, 4'hC, 6'h01};
			ang <= k ? 16'hB800 : 16'h5800;
			rst_n <= 1'b0;
			repeat (4) @(posedge clk);
			rst_n <= 1'b1;
			repeat (3) @(posedge clk);
			for (w = 0; busy !== 1'b0 && w < 900; w = w + 1)
				@(posedge clk);
			// pins lag the last step by one edge, the receiver by two
			repeat (2) @(negedge clk);
			check(cnt, k ? 16'hFFFB : 16'h0005);
			put(ang, k ? 3'h4 : 3'h2);
		end
		$display("catch-up test done");
		give_verdict;
	end
endmodule // incremental_commutation_output_test
